/* File: hw/sesu_top.sv */
// Contract
// [R1] Clear-status empties the error queue, returns completion to idle and zeroes the event register but keeps the mask.
// [R2] The enable mask takes any value 0 to 255 from the controller and resets to zero.
// [R3] Status byte bit 5 is the OR of every event bit whose mask bit is set.
// [R4] Event and mask share one layout: 5 command, 4 execution, 3 device, 2 query, 0 completion, 7/6/1 unused.
// [R5] The mask query returns the stored mask unchanged.
// [R6] The event query returns the register and then clears it.
// [R7] A 1xx error sets the command error bit.
// [R8] A 2xx error sets the execution error bit.
// [R9] A 3xx error, or a current/voltage error with its questionable bit, sets the device error bit.
// [R10] A 4xx error sets the query error bit.
// [R11] The identity reply is four comma separated fields: maker, model-rating-date, serial, firmware.
// [R12] The date reads MM/DD/YYYY and the serial has six digits.
// [R13] The controller marks each common command with a leading asterisk.
// [R14] After the completion command clears bit 0, it sets again only when all work is done.
// [R15] Unused event bits read zero and unused mask bits never reach the summary bit.
`timescale 1ns/1ps
`include "sesu_defines.svh"
module sesu_top
  import sesu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire sesu_cmd_t   cmd,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        err_valid,
  input  wire logic [3:0]  err_class,
  input  wire logic        err_meas_ques,
  input  wire logic        ops_pending,
  input  wire logic [7:0]  mfr_char [0:7],
  input  wire logic [7:0]  model_char [0:7],
  input  wire logic [7:0]  rating_char [0:7],
  input  wire logic [7:0]  cal_month,
  input  wire logic [7:0]  cal_day,
  input  wire logic [15:0] cal_year,
  input  wire logic [23:0] serial_bcd,
  input  wire logic [15:0] fw_bcd,
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  output logic             rsp_last,
  output logic             esb,
  output logic             err_queue_clear
);
  logic [7:0]   enable_ff;
  logic [7:0]   event_ff;
  sesu_opc_st_t opc_ff;
  logic [7:0]   rsp_ff;
  logic         rsp_valid_ff;
  logic         esb_ff;
  logic         eqc_ff;
  logic         idn_busy_ff;
  logic [6:0]   idn_idx_ff;
  logic [7:0]   nxt_enable;
  logic [7:0]   nxt_event;
  sesu_opc_st_t nxt_opc;
  logic [7:0]   nxt_rsp;
  logic         nxt_rsp_valid;
  logic         nxt_eqc;
  logic         nxt_idn_busy;
  logic [6:0]   nxt_idn_idx;
  logic [7:0]   set_bits;
  logic         nxt_esb;

  sesu_id_if id_bus ();

  sesu_id_gen u_id (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .mfr_char    (mfr_char),
    .model_char  (model_char),
    .rating_char (rating_char),
    .cal_month   (cal_month),
    .cal_day     (cal_day),
    .cal_year    (cal_year),
    .serial_bcd  (serial_bcd),
    .fw_bcd      (fw_bcd),
    .id          (id_bus)
  );

  function automatic logic is_class(input logic [3:0] c, input logic [3:0] k);
    is_class = err_valid && (c == k);
  endfunction

  // Events this cycle; these win over a same-cycle read clear
  always_comb begin
    set_bits = 8'h00;
    set_bits[`SESU_BIT_CME] = is_class(err_class, `SESU_CLASS_CMD); // R7
    set_bits[`SESU_BIT_EXE] = is_class(err_class, `SESU_CLASS_EXE); // R8
    set_bits[`SESU_BIT_DDE] = is_class(err_class, `SESU_CLASS_DEV) | err_meas_ques; // R9
    set_bits[`SESU_BIT_QYE] = is_class(err_class, `SESU_CLASS_QRY); // R10
    set_bits[`SESU_BIT_OPC] = (opc_ff == SESU_OPC_WAIT) && !ops_pending; // R14
  end

  always_comb begin
    nxt_enable    = enable_ff;
    nxt_event     = event_ff;
    nxt_opc       = opc_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp_valid = 1'b0;
    nxt_eqc       = 1'b0;
    nxt_idn_busy  = idn_busy_ff;
    nxt_idn_idx   = idn_idx_ff;
    if (set_bits[`SESU_BIT_OPC]) begin
      nxt_opc = SESU_OPC_IDLE; // R14
    end
    case (cmd)
      SESU_CMD_CLS: begin
        nxt_event = 8'h00; // R1
        nxt_opc   = SESU_OPC_IDLE; // R1
        nxt_eqc   = 1'b1; // R1
      end
      SESU_CMD_ESE_WR: nxt_enable = cmd_data; // R2
      SESU_CMD_ESE_RD: begin
        nxt_rsp       = enable_ff; // R5
        nxt_rsp_valid = 1'b1;
      end
      SESU_CMD_ESR_RD: begin
        nxt_rsp       = event_ff & `SESU_USED_MASK; // R6 R15
        nxt_rsp_valid = 1'b1;
        nxt_event     = 8'h00; // R6
      end
      SESU_CMD_OPC: begin
        nxt_event[`SESU_BIT_OPC] = 1'b0; // R14
        nxt_opc                  = SESU_OPC_WAIT;
      end
      SESU_CMD_IDN_RD: begin
        nxt_idn_busy = 1'b1;
        nxt_idn_idx  = 7'h00;
      end
      default: nxt_rsp = rsp_ff;
    endcase
    if (cmd == SESU_CMD_OPC) begin
      nxt_event = nxt_event | (set_bits & ~8'h01);
    end else begin
      nxt_event = nxt_event | set_bits;
    end
    nxt_event = nxt_event & `SESU_USED_MASK; // R4 R15
    if (idn_busy_ff) begin
      nxt_idn_idx = idn_idx_ff + 7'h01;
      if (idn_idx_ff == `SESU_ID_LEN - 7'h01) begin
        nxt_idn_busy = 1'b0;
      end
    end
    // Identity characters own the reply path; a query sent meanwhile would collide
    if (id_bus.valid) begin
      nxt_rsp       = id_bus.char_out; // R11
      nxt_rsp_valid = 1'b1;
    end
    nxt_esb = |(nxt_event & nxt_enable & `SESU_USED_MASK); // R3 R15
  end

  assign id_bus.start = idn_busy_ff;
  assign id_bus.index = idn_idx_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_ff    <= `SESU_ENABLE_RST; // R2
      event_ff     <= `SESU_EVENT_RST;
      opc_ff       <= SESU_OPC_IDLE;
      rsp_ff       <= 8'h00;
      rsp_valid_ff <= 1'b0;
      esb_ff       <= 1'b0;
      eqc_ff       <= 1'b0;
      idn_busy_ff  <= 1'b0;
      idn_idx_ff   <= 7'h00;
    end else begin
      enable_ff    <= nxt_enable;
      event_ff     <= nxt_event;
      opc_ff       <= nxt_opc;
      rsp_ff       <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
      esb_ff       <= nxt_esb;
      eqc_ff       <= nxt_eqc;
      idn_busy_ff  <= nxt_idn_busy;
      idn_idx_ff   <= nxt_idn_idx;
    end
  end

  // Identity stream is delayed one cycle by the reply register
  logic last_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= id_bus.last;
    end
  end

  assign rsp_data        = rsp_ff;
  assign rsp_valid       = rsp_valid_ff;
  assign rsp_last        = last_ff;
  assign esb             = esb_ff;
  assign err_queue_clear = eqc_ff;

  chk_esr_read_clears: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
    (cmd == SESU_CMD_ESR_RD && !err_valid && !err_meas_ques && opc_ff == SESU_OPC_IDLE)
      |=> (event_ff == 8'h00)) else $error("event read did not clear");
  chk_cls_keeps_mask: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
    (cmd == SESU_CMD_CLS) |=> (enable_ff == $past(enable_ff) && eqc_ff))
    else $error("clear status changed mask");
  chk_mask_write_lands: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
    (cmd == SESU_CMD_ESE_WR) |=> (enable_ff == $past(cmd_data)))
    else $error("mask write lost");
  chk_cmd_error_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (err_valid && err_class == 4'h1) |=> event_ff[5]) else $error("1xx lost"); // R7
  chk_exe_error_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (err_valid && err_class == 4'h2) |=> event_ff[4]) else $error("2xx lost"); // R8
  chk_dev_error_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
    (err_meas_ques || (err_valid && err_class == 4'h3)) |=> event_ff[3])
    else $error("device error lost");
  chk_qry_error_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (err_valid && err_class == 4'h4) |=> event_ff[2]) else $error("4xx lost"); // R10
  chk_esb_summary: assert property (@(posedge clk_sys) disable iff (!reset_n)
    esb_ff == |(event_ff & enable_ff)) else $error("summary bit wrong"); // R3
  chk_unused_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (event_ff & 8'hC2) == 8'h00) else $error("unused event bit set"); // R15
  chk_opc_waits: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    (opc_ff == SESU_OPC_WAIT && ops_pending && cmd != SESU_CMD_CLS)
      |=> !event_ff[0] || $past(cmd) == SESU_CMD_NONE && $past(event_ff[0]))
    else $error("completion bit early");
  // A set in the same cycle as a read clear must still land
  chk_opc_sets_done: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    (opc_ff == SESU_OPC_WAIT && !ops_pending && cmd != SESU_CMD_OPC) |=> event_ff[0])
    else $error("completion bit missing");
  chk_ese_readback: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
    (cmd == SESU_CMD_ESE_RD) |=> (rsp_valid_ff && rsp_ff == $past(enable_ff)))
    else $error("mask readback wrong");
  cov_idn_done: cover property (@(posedge clk_sys) disable iff (!reset_n) last_ff);
  cov_esb_high: cover property (@(posedge clk_sys) disable iff (!reset_n) esb_ff);
  cov_cls_seen: cover property (@(posedge clk_sys) disable iff (!reset_n) eqc_ff);
  cov_opc_done: cover property (@(posedge clk_sys) disable iff (!reset_n)
    opc_ff == SESU_OPC_WAIT ##1 opc_ff == SESU_OPC_IDLE);
endmodule

/* File: hw/sesu_defines.svh */
`ifndef SESU_DEFINES_SVH
`define SESU_DEFINES_SVH

// Event register and enable mask layout, shared by both
`define SESU_BIT_OPC     0
`define SESU_BIT_QYE     2
`define SESU_BIT_DDE     3
`define SESU_BIT_EXE     4
`define SESU_BIT_CME     5
`define SESU_USED_MASK   8'h3D
`define SESU_ENABLE_RST  8'h00
`define SESU_EVENT_RST   8'h00
`define SESU_STB_ESB     5

// Error class digit of a reported error code
`define SESU_CLASS_CMD   4'h1
`define SESU_CLASS_EXE   4'h2
`define SESU_CLASS_DEV   4'h3
`define SESU_CLASS_QRY   4'h4

// Identification string shape
`define SESU_ID_LEN      7'h32
`define SESU_SERIAL_DIG  6
`define SESU_ASCII_COMMA 8'h2C
`define SESU_ASCII_SLASH 8'h2F
`define SESU_ASCII_SPACE 8'h20
`define SESU_ASCII_ZERO  8'h30
`define SESU_ASCII_DASH  8'h2D
`define SESU_ASCII_DOT   8'h2E

`endif

/* File: hw/sesu_pkg.sv */
package sesu_pkg;
  typedef enum logic [2:0] {
    SESU_CMD_NONE,
    SESU_CMD_CLS,
    SESU_CMD_ESE_WR,
    SESU_CMD_ESE_RD,
    SESU_CMD_ESR_RD,
    SESU_CMD_OPC,
    SESU_CMD_IDN_RD
  } sesu_cmd_t;

  typedef enum logic [1:0] {
    SESU_OPC_IDLE,
    SESU_OPC_WAIT
  } sesu_opc_st_t;
endpackage

/* File: hw/sesu_id_if.sv */
`timescale 1ns/1ps
interface sesu_id_if;
  logic       start;
  logic [6:0] index;
  logic       valid;
  logic [7:0] char_out;
  logic       last;
  modport gen (input start, input index, output valid, output char_out, output last);
  modport use_side (output start, output index, input valid, input char_out, input last);
endinterface

/* File: hw/sesu_id_gen.sv */
`timescale 1ns/1ps
`include "sesu_defines.svh"
module sesu_id_gen
  import sesu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  mfr_char [0:7],
  input  wire logic [7:0]  model_char [0:7],
  input  wire logic [7:0]  rating_char [0:7],
  input  wire logic [7:0]  cal_month,
  input  wire logic [7:0]  cal_day,
  input  wire logic [15:0] cal_year,
  input  wire logic [23:0] serial_bcd,
  input  wire logic [15:0] fw_bcd,
  sesu_id_if.gen           id
);
  logic [7:0] nxt_char;
  logic       nxt_last;
  logic [7:0] char_ff;
  logic       valid_ff;
  logic       last_ff;

  function automatic logic [7:0] digit(input logic [3:0] d);
    digit = `SESU_ASCII_ZERO + {4'h0, d};
  endfunction

  // Layout: mfr , model rating MM/DD/YYYY , serial6 , fw  (11,12)
  always_comb begin
    nxt_char = `SESU_ASCII_SPACE;
    nxt_last = 1'b0;
    case (id.index)
      7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07: nxt_char = mfr_char[id.index[2:0]];
      7'h08: nxt_char = `SESU_ASCII_COMMA; // R11
      7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10: nxt_char = model_char[id.index[2:0] - 3'h1];
      7'h11: nxt_char = `SESU_ASCII_SPACE;
      7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19: nxt_char = rating_char[id.index[2:0] - 3'h2];
      7'h1A: nxt_char = `SESU_ASCII_SPACE;
      7'h1B: nxt_char = digit(cal_month[7:4]); // R12
      7'h1C: nxt_char = digit(cal_month[3:0]);
      7'h1D: nxt_char = `SESU_ASCII_SLASH;
      7'h1E: nxt_char = digit(cal_day[7:4]);
      7'h1F: nxt_char = digit(cal_day[3:0]);
      7'h20: nxt_char = `SESU_ASCII_SLASH;
      7'h21: nxt_char = digit(cal_year[15:12]);
      7'h22: nxt_char = digit(cal_year[11:8]);
      7'h23: nxt_char = digit(cal_year[7:4]);
      7'h24: nxt_char = digit(cal_year[3:0]);
      7'h25: nxt_char = `SESU_ASCII_COMMA; // R11
      7'h26: nxt_char = digit(serial_bcd[23:20]); // R12
      7'h27: nxt_char = digit(serial_bcd[19:16]);
      7'h28: nxt_char = digit(serial_bcd[15:12]);
      7'h29: nxt_char = digit(serial_bcd[11:8]);
      7'h2A: nxt_char = digit(serial_bcd[7:4]);
      7'h2B: nxt_char = digit(serial_bcd[3:0]);
      7'h2C: nxt_char = `SESU_ASCII_COMMA;
      7'h2D: nxt_char = digit(fw_bcd[15:12]);
      7'h2E: nxt_char = digit(fw_bcd[11:8]);
      7'h2F: nxt_char = `SESU_ASCII_DOT;
      7'h30: nxt_char = digit(fw_bcd[7:4]);
      7'h31: begin
        nxt_char = digit(fw_bcd[3:0]);
        nxt_last = 1'b1;
      end
      default: nxt_char = `SESU_ASCII_SPACE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      char_ff  <= 8'h00;
      valid_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else begin
      char_ff  <= nxt_char;
      valid_ff <= id.start;
      last_ff  <= nxt_last & id.start;
    end
  end

  assign id.char_out = char_ff;
  assign id.valid    = valid_ff;
  assign id.last     = last_ff;
endmodule

/* File: tb/sesu_ctl_model.sv */
`timescale 1ns/1ps
module sesu_ctl_model
  import sesu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       req_valid,
  input  wire sesu_cmd_t  req_cmd,
  input  wire logic [7:0] req_data,
  input  wire logic       op_start,
  input  wire logic [7:0] op_len,
  output sesu_cmd_t       cmd,
  output logic [7:0]      cmd_data,
  output logic            ops_pending
);
  logic [7:0] busy_ff;
  logic [7:0] nxt_busy;

  // Only common commands reach this point; the leading asterisk is already parsed
  assign cmd         = req_valid ? req_cmd : SESU_CMD_NONE;
  // Idle data shows the inverse of req_data so a late read cannot pass by luck
  assign cmd_data    = req_valid ? req_data : ~req_data;
  assign ops_pending = (busy_ff != 8'h00);

  always_comb begin
    nxt_busy = busy_ff;
    if (op_start) begin
      nxt_busy = op_len;
    end else if (busy_ff != 8'h00) begin
      nxt_busy = busy_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 8'h00;
    end else begin
      busy_ff <= nxt_busy;
    end
  end
endmodule

/* File: tb/tb_standard_event_status_unit.sv */
`timescale 1ns/1ps
module tb_standard_event_status_unit
  import sesu_pkg::*;
;
  logic        clk_sys;
  logic        reset_n;
  logic        req_valid;
  sesu_cmd_t   req_cmd;
  logic [7:0]  req_data;
  logic        op_start;
  logic [7:0]  op_len;
  sesu_cmd_t   cmd;
  logic [7:0]  cmd_data;
  logic        ops_pending;
  logic        err_valid;
  logic [3:0]  err_class;
  logic        err_meas_ques;
  logic [7:0]  mfr_char [0:7];
  logic [7:0]  model_char [0:7];
  logic [7:0]  rating_char [0:7];
  logic [7:0]  rsp_data;
  logic        rsp_valid;
  logic        rsp_last;
  logic        esb;
  logic        err_queue_clear;
  int          err_count;
  int          tests_run;
  int          n;
  int          last_n;
  // Maker, model and rating are arbitrary identity values
  string       idn = "MAKERXYZ,MODEL123 0036-028 09/30/2001,123456,04.01";

  sesu_ctl_model ctl (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_data(req_data), .op_start(op_start), .op_len(op_len),
    .cmd(cmd), .cmd_data(cmd_data), .ops_pending(ops_pending));

  sesu_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .cmd_data(cmd_data),
    .err_valid(err_valid), .err_class(err_class), .err_meas_ques(err_meas_ques),
    .ops_pending(ops_pending), .mfr_char(mfr_char), .model_char(model_char),
    .rating_char(rating_char), .cal_month(8'h09), .cal_day(8'h30), .cal_year(16'h2001),
    .serial_bcd(24'h123456), .fw_bcd(16'h0401), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .esb(esb),
    .err_queue_clear(err_queue_clear));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held for exactly one taking edge; returns just after it
  task automatic issue(input sesu_cmd_t c, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    req_data = d;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic rd(input sesu_cmd_t c, input logic [7:0] exp, input string what);
    issue(c, 8'h00);
    chk("reply strobe", 8'h01, {7'h00, rsp_valid});
    chk(what, exp, rsp_data);
  endtask

  task automatic raise(input logic [3:0] cls, input logic meas);
    @(posedge clk_sys);
    #1;
    err_valid = ~meas;
    err_meas_ques = meas;
    err_class = cls;
    @(posedge clk_sys);
    #1;
    err_valid = 1'b0;
    err_meas_ques = 1'b0;
  endtask

  initial begin
    #100000;
    err_count++;
    $display("unexpected watchdog: expected end seen timeout");
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = SESU_CMD_NONE;
    req_data = 8'h00;
    op_start = 1'b0;
    op_len = 8'h00;
    err_valid = 1'b0;
    err_class = 4'h0;
    err_meas_ques = 1'b0;
    err_count = 0;
    tests_run = 0;
    for (int i = 0; i < 8; i++) begin
      mfr_char[i] = idn[i];
      model_char[i] = idn[9 + i];
      rating_char[i] = idn[18 + i];
    end
    repeat (5) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    rd(SESU_CMD_ESE_RD, 8'h00, "mask at reset");
    rd(SESU_CMD_ESR_RD, 8'h00, "events at reset");
    for (int i = 1; i <= 4; i++) begin
      raise(i[3:0], 1'b0);
      rd(SESU_CMD_ESR_RD, 8'h01 << (6 - i), "event class");
      rd(SESU_CMD_ESR_RD, 8'h00, "event reread");
    end
    raise(4'h0, 1'b1);
    rd(SESU_CMD_ESR_RD, 8'h08, "measure error");
    issue(SESU_CMD_ESE_WR, 8'hFF);
    rd(SESU_CMD_ESE_RD, 8'hFF, "mask full");
    rd(SESU_CMD_ESE_RD, 8'hFF, "mask reread");
    // Only unused positions enabled: a command error must stay out of the summary
    issue(SESU_CMD_ESE_WR, 8'hC2);
    raise(4'h1, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("summary unused mask", 8'h00, {7'h00, esb});
    issue(SESU_CMD_ESE_WR, 8'h3C);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("summary enabled", 8'h01, {7'h00, esb});
    issue(SESU_CMD_CLS, 8'h00);
    chk("queue clear", 8'h01, {7'h00, err_queue_clear});
    rd(SESU_CMD_ESR_RD, 8'h00, "events after clear");
    chk("summary after clear", 8'h00, {7'h00, esb});
    rd(SESU_CMD_ESE_RD, 8'h3C, "mask after clear");
    raise(4'h2, 1'b0);
    chk("summary same cycle", 8'h01, {7'h00, esb});
    rd(SESU_CMD_ESR_RD, 8'h10, "execution event");
    @(posedge clk_sys);
    #1;
    op_start = 1'b1;
    op_len = 8'h0A;
    @(posedge clk_sys);
    #1;
    op_start = 1'b0;
    issue(SESU_CMD_OPC, 8'h00);
    repeat (3) @(posedge clk_sys);
    rd(SESU_CMD_ESR_RD, 8'h00, "busy completion");
    repeat (12) @(posedge clk_sys);
    rd(SESU_CMD_ESR_RD, 8'h01, "done completion");
    issue(SESU_CMD_IDN_RD, 8'h00);
    n = 0;
    last_n = 0;
    repeat (70) begin
      @(posedge clk_sys);
      #1;
      // Every strobe is counted so that a stream running long fails the length check
      if (rsp_valid === 1'b1) begin
        if (n < 50) begin
          chk("identity char", idn[n], rsp_data);
        end
        n++;
      end
      if (rsp_last === 1'b1) begin
        last_n = n;
      end
    end
    chk("identity length", 8'h32, n[7:0]);
    chk("identity last", 8'h32, last_n[7:0]);
    end_of_test();
  end
endmodule
